// ===== rtl/fdsup_core.sv
`timescale 1ns/10ps
module fdsup_core import fdsup_pkg::*; #(
    parameter int unsigned DIAG_CYCLES = DIAG_PASS_CYC
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_standby_n, // standby pin, low = standby
    input wire fdsup_prot_t i_prot, // raw detector flags
    input wire fdsup_load_t i_load, // raw load comparators
    input wire logic i_fault_pin, // level seen on fault wire
    input wire logic i_ctrl_wr, // host writes control byte
    input wire logic [7:0] i_ctrl_data, // byte for register 0x03
    input wire logic i_status_clr, // host clears sticky status
    input wire logic signed [7:0] i_level, // modulator demand
    output logic o_bridge_out_pos, // positive leg drive
    output logic o_bridge_out_neg, // negative leg drive
    output logic o_bridge_oe_n, // high = bridge hi-z
    output logic o_fault_out, // fault wire data, always low
    output logic o_fault_oe_n, // low = pulling fault wire
    output logic o_bus_release, // serial port must float
    output logic [7:0] o_ctrl, // control byte readback
    output logic [1:0] o_gain_sel, // gain code
    output logic [5:0] o_gain_db, // gain in dB
    output fdsup_stat_t o_status // host status
);
    // ****************************************
    // input capture
    // ****************************************
    localparam int unsigned SYNC_W = 13; // all pin level inputs
    logic [SYNC_W-1:0] sync_vec; // synchronised pins
    fdsup_prot_t prot; // clean detector flags
    fdsup_load_t load; // clean load flags
    logic standby; // standby asserted
    logic fault_line; // observed fault wire
    fdsup_sync2 #(.WIDTH(SYNC_W)) u_sync (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_async({i_prot, i_load, i_standby_n, ~i_fault_pin}),
        .o_sync(sync_vec)
    );
    assign prot = fdsup_prot_t'(sync_vec[12:7]);
    assign load = fdsup_load_t'(sync_vec[6:2]);
    // enter inverted so a flushed stage reads standby and idle wire
    assign standby = ~sync_vec[1];
    assign fault_line = ~sync_vec[0];

    // ****************************************
    // derived conditions
    // ****************************************
    fdsup_state_t state; // supervisor state
    logic [DIAG_CNT_W-1:0] diag_cnt; // pass timer
    logic [2:0] pass_cnt; // check passes done
    logic pass_end; // last cycle of a pass
    logic ov_q; // overvoltage last cycle
    logic ov_rise; // new overvoltage event
    logic ov_par; // odd overvoltage seen
    logic need_diag; // diagnostic owed after hold
    logic diag_fault; // last verdict was a hard fault
    logic regs_clear; // registers back to defaults
    logic off; // standby or power-on reset
    logic supply_trip; // thermal or supply trip
    logic hold_cause; // any hold condition alive
    logic load_bad; // pass saw fault or big cap
    fdsup_verdict_t verdict_now; // verdict of this pass
    logic fault_drive; // pull fault wire low
    assign off = standby | prot.power_on_reset;
    // undervoltage also wipes the registers
    assign regs_clear = off | prot.supply_low_trip;
    assign supply_trip = prot.overtemp_shutdown | prot.supply_high_trip
        | prot.supply_low_trip;
    // dc offset only counts while playing
    assign hold_cause = supply_trip | prot.overcurrent_shutdown
        | (prot.dc_offset & (state == FDSUP_PLAY));
    assign ov_rise = prot.supply_high_trip & ~ov_q;
    assign pass_end = (state == FDSUP_DIAG)
        && (diag_cnt == DIAG_CNT_W'(DIAG_CYCLES - 1));
    assign load_bad = load.short_gnd | load.short_rail
        | load.shorted_load | load.big_cap;

    // ****************************************
    // verdict decode, shorts outrank open
    // ****************************************
    assign verdict_now = load.short_gnd ? FDSUP_V_GND
        : load.short_rail ? FDSUP_V_RAIL
        : load.shorted_load ? FDSUP_V_SHORTED
        : load.open_load ? FDSUP_V_OPEN : FDSUP_V_NORMAL;

    // ****************************************
    // overvoltage parity
    // ****************************************
    // toggles per event so every second one owes a diagnostic
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            ov_q <= 1'b0;
            ov_par <= 1'b0;
        end else begin
            ov_q <= prot.supply_high_trip;
            if (ov_rise) ov_par <= ~ov_par;
        end
    end

    // ****************************************
    // supervisor state machine
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_nrst || off) begin
            state <= FDSUP_STBY;
            need_diag <= 1'b0;
        end else begin
            case (state)
                FDSUP_STBY: state <= FDSUP_DIAG;
                FDSUP_DIAG: begin
                    // abort at once, pop accepted over damage
                    if (supply_trip || prot.overcurrent_shutdown) begin
                        state <= FDSUP_HOLD;
                        need_diag <= 1'b1;
                    end else if (pass_end && !load_bad
                        && !diag_fault) begin
                        state <= FDSUP_PLAY;
                        need_diag <= 1'b0;
                    end
                end
                FDSUP_PLAY: begin
                    if (hold_cause) begin
                        state <= FDSUP_HOLD;
                        // only an odd-numbered overvoltage with no other cause skips the check
                        need_diag <= ~(ov_rise & ~ov_par)
                            | prot.overcurrent_shutdown
                            | prot.overtemp_shutdown
                            | prot.supply_low_trip | prot.dc_offset;
                    end
                end
                FDSUP_HOLD: begin
                    if (!hold_cause) begin
                        state <= need_diag ? FDSUP_DIAG : FDSUP_PLAY;
                    end else if (ov_rise && ov_par) begin
                        need_diag <= 1'b1;
                    end
                end
                default: state <= FDSUP_STBY;
            endcase
        end
    end

    // ****************************************
    // diagnostic pass timer and pass count
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_nrst || state != FDSUP_DIAG) begin
            diag_cnt <= '0;
            pass_cnt <= 3'h0;
        end else if (pass_end) begin
            diag_cnt <= '0;
            // repeat checks while bad; past the limit keep looping
            if (load_bad && pass_cnt < CHECK_PASSES - 3'h1) begin
                pass_cnt <= pass_cnt + 3'h1;
            end else begin
                pass_cnt <= 3'h0;
            end
        end else begin
            diag_cnt <= diag_cnt + DIAG_CNT_W'(1);
        end
    end

    // ****************************************
    // hard fault verdict flag
    // ****************************************
    // only the last pass of a check run decides the verdict
    always_ff @(posedge i_clk) begin
        if (!i_nrst || off) begin
            diag_fault <= 1'b0;
        end else if (pass_end && (!load_bad
            || pass_cnt == CHECK_PASSES - 3'h1)) begin
            diag_fault <= load_bad & ~load.big_cap;
        end
    end

    // ****************************************
    // control byte
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_nrst || regs_clear) begin
            o_ctrl <= CTRL_RST;
        end else if (i_ctrl_wr) begin
            o_ctrl <= i_ctrl_data;
        end
    end

    // gain decode, registered one cycle behind the byte
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_gain_sel <= 2'h0;
            o_gain_db <= GAIN_DB0;
        end else begin
            o_gain_sel <= o_ctrl[GAIN_MSB:GAIN_LSB];
            case (o_ctrl[GAIN_MSB:GAIN_LSB])
                2'h0: o_gain_db <= GAIN_DB0;
                2'h1: o_gain_db <= GAIN_DB1;
                2'h2: o_gain_db <= GAIN_DB2;
                2'h3: o_gain_db <= GAIN_DB3;
                default: o_gain_db <= GAIN_DB0;
            endcase
        end
    end

    // ****************************************
    // host status, set wins over clear
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_nrst || off) begin
            o_status <= STAT_RST;
        end else begin
            if (regs_clear) begin
                // undervoltage wipes all but its own mark
                o_status <= STAT_RST;
                o_status.supply_low_trip <= 1'b1;
            end else if (i_status_clr) begin
                o_status.overcurrent_shutdown <= 1'b0;
                o_status.dc_offset <= 1'b0;
                o_status.overtemp_shutdown <= 1'b0;
                o_status.supply_low_trip <= 1'b0;
                o_status.supply_high_trip <= 1'b0;
            end
            if (prot.overcurrent_shutdown) begin
                o_status.overcurrent_shutdown <= 1'b1;
            end
            if (prot.dc_offset && state == FDSUP_PLAY) begin
                o_status.dc_offset <= 1'b1;
            end
            if (prot.overtemp_shutdown) begin
                o_status.overtemp_shutdown <= 1'b1;
            end
            if (prot.supply_high_trip) begin
                o_status.supply_high_trip <= 1'b1;
            end
            if (pass_end && (!load_bad
                || pass_cnt == CHECK_PASSES - 3'h1)) begin
                o_status.verdict <= verdict_now;
            end
            o_status.diag_busy <= (state == FDSUP_DIAG);
            o_status.fault_line <= fault_line;
        end
    end

    // ****************************************
    // fault wire and serial port release
    // ****************************************
    // open load never reaches diag_fault, so it stays off the wire
    assign fault_drive = (state == FDSUP_HOLD)
        | ((state == FDSUP_DIAG) & diag_fault)
        | prot.supply_high_trip | prot.supply_low_trip;

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_fault_oe_n <= 1'b1;
            o_bus_release <= 1'b1;
        end else begin
            o_fault_oe_n <= ~fault_drive;
            o_bus_release <= off;
        end
    end
    assign o_fault_out = 1'b0; // open drain only pulls low

    // ****************************************
    // limiter and modulator
    // ****************************************
    logic [7:0] pwm_cnt; // carrier ramp
    logic signed [7:0] lim; // symmetric limit
    logic signed [7:0] lvl; // clamped demand
    logic bridge_off; // hold bridge hi-z

    assign bridge_off = (state != FDSUP_PLAY);
    // odd step keeps limit above zero and inside 127
    assign lim = $signed({1'b0, o_ctrl[LIM_MSB:LIM_LSB], 1'b1});
    // one limit, mirrored for the negative side
    assign lvl = (i_level > lim) ? lim
        : (i_level < -lim) ? -lim : i_level;

    // both legs centred on half duty, moved in opposite ways
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            pwm_cnt <= 8'h00;
            o_bridge_out_pos <= 1'b0;
            o_bridge_out_neg <= 1'b0;
            o_bridge_oe_n <= 1'b1;
        end else begin
            pwm_cnt <= pwm_cnt + 8'h01;
            o_bridge_oe_n <= bridge_off;
            if (bridge_off) begin
                o_bridge_out_pos <= 1'b0;
                o_bridge_out_neg <= 1'b0;
            end else begin
                o_bridge_out_pos <= pwm_cnt < PWM_MID + lvl;
                o_bridge_out_neg <= pwm_cnt < PWM_MID - lvl;
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    diag_hiz_a: assert property (
        state == FDSUP_DIAG |=> o_bridge_oe_n)
        else $error("bridge driven during diagnostic");
    diag_abort_a: assert property (
        state == FDSUP_DIAG && supply_trip && !off
        |=> state == FDSUP_HOLD)
        else $error("diagnostic not aborted on trip");
    pass_len_a: assert property (
        diag_cnt < DIAG_CNT_W'(DIAG_CYCLES))
        else $error("pass timer overran");
    pass_limit_a: assert property (
        pass_cnt < CHECK_PASSES)
        else $error("too many check passes");
    open_play_a: assert property (
        pass_end && verdict_now == FDSUP_V_OPEN && !load.big_cap
        && !diag_fault && !supply_trip && !off
        && !prot.overcurrent_shutdown |=> state == FDSUP_PLAY)
        else $error("open load blocked playback");
    ov_parity_a: assert property (
        ov_rise |=> ov_par != $past(ov_par))
        else $error("overvoltage parity not toggled");
    uv_reset_a: assert property (
        prot.supply_low_trip |=> o_ctrl == CTRL_RST
        ##1 !o_fault_oe_n)
        else $error("undervoltage did not reset");
    stby_bus_a: assert property (
        standby |=> o_bus_release && state == FDSUP_STBY)
        else $error("bus not released in standby");
    in_phase_a: assert property (
        !bridge_off && lvl == 8'sh00
        |=> o_bridge_out_pos == o_bridge_out_neg)
        else $error("legs out of phase at zero");
    oc_hold_a: assert property (
        state == FDSUP_PLAY && prot.overcurrent_shutdown && !off
        |=> state == FDSUP_HOLD ##1 o_bridge_oe_n && !o_fault_oe_n)
        else $error("overcurrent not handled");

    diag_done_c: cover property (state == FDSUP_DIAG ##1 state == FDSUP_PLAY);
    repeat_c: cover property (pass_end && pass_cnt == 3'h4);
    hold_back_c: cover property (state == FDSUP_HOLD ##1 state == FDSUP_DIAG);
    ov_skip_c: cover property (state == FDSUP_HOLD ##1 state == FDSUP_PLAY);
endmodule

// ===== rtl/fdsup_pkg.sv
package fdsup_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int unsigned CLK_HZ = 50000000; // core clock rate
    localparam int unsigned DIAG_PASS_MS = 229; // one diagnostic pass
    // cycles per pass; fits 24 bits with room to spare
    localparam int unsigned DIAG_PASS_CYC = DIAG_PASS_MS * (CLK_HZ / 1000);
    localparam int unsigned DIAG_CNT_W = 24; // pass timer width
    localparam logic [2:0] CHECK_PASSES = 3'h5; // check passes at most

    // ****************************************
    // control byte at register 0x03
    // ****************************************
    localparam logic [7:0] CTRL_ADDR = 8'h03; // register index
    localparam int unsigned GAIN_MSB = 7; // gain field top bit
    localparam int unsigned GAIN_LSB = 6; // gain field low bit
    localparam int unsigned LIM_MSB = 5; // limiter field top bit
    localparam int unsigned LIM_LSB = 0; // limiter field low bit
    localparam logic [7:0] CTRL_RST = 8'h00; // value after reset
    // gain in dB for codes 00, 01, 10, 11
    localparam logic [5:0] GAIN_DB0 = 6'h14;
    localparam logic [5:0] GAIN_DB1 = 6'h1a;
    localparam logic [5:0] GAIN_DB2 = 6'h20;
    localparam logic [5:0] GAIN_DB3 = 6'h24;

    // ****************************************
    // modulator
    // ****************************************
    localparam logic [7:0] PWM_MID = 8'h80; // 50% duty point

    // ****************************************
    // types
    // ****************************************
    // protection detector flags from the analog side
    typedef struct packed {
        logic overcurrent_shutdown;
        logic dc_offset;
        logic overtemp_shutdown;
        logic supply_low_trip;
        logic supply_high_trip;
        logic power_on_reset;
    } fdsup_prot_t;

    // load comparator outputs sampled by the diagnostic
    typedef struct packed {
        logic short_gnd;
        logic short_rail;
        logic shorted_load;
        logic open_load;
        logic big_cap;
    } fdsup_load_t;

    // diagnostic verdict codes
    typedef enum logic [2:0] {
        FDSUP_V_NONE = 3'h0,
        FDSUP_V_NORMAL = 3'h1,
        FDSUP_V_GND = 3'h2,
        FDSUP_V_RAIL = 3'h3,
        FDSUP_V_OPEN = 3'h4,
        FDSUP_V_SHORTED = 3'h5
    } fdsup_verdict_t;

    // status seen by the host over the serial port
    typedef struct packed {
        logic overcurrent_shutdown;
        logic dc_offset;
        logic overtemp_shutdown;
        logic supply_low_trip;
        logic supply_high_trip;
        fdsup_verdict_t verdict;
        logic diag_busy;
        logic fault_line;
    } fdsup_stat_t;

    localparam fdsup_stat_t STAT_RST = '{default: 1'b0,
        verdict: FDSUP_V_NONE};

    // supervisor states, gray along standby-diag-play-hold
    typedef enum logic [1:0] {
        FDSUP_STBY = 2'h0,
        FDSUP_DIAG = 2'h1,
        FDSUP_PLAY = 2'h3,
        FDSUP_HOLD = 2'h2
    } fdsup_state_t;
endpackage

// ===== rtl/fdsup_sync2.sv
`timescale 1ns/10ps
// two flop synchroniser; first stage feeds only the second
module fdsup_sync2 #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta; // metastability catcher

    // ****************************************
    // two stage capture
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            meta <= '0;
            o_sync <= '0;
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule

// ===== verification/fdsup_host_model.sv
`timescale 1ns/10ps
// host side of the fault wire: pull-up, no drive of its own
module fdsup_host_model (
    input wire logic i_fault_out, // device data, low when pulling
    input wire logic i_fault_oe_n, // low = device pulls the wire
    output logic o_fault_pin // level the host and device see
);
    // released open drain reads the pull-up level
    assign o_fault_pin = i_fault_oe_n ? 1'b1 : i_fault_out;
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/10ps
module tb_top import fdsup_pkg::*;;
    // ****************************************
    // stimulus and observed signals
    // ****************************************
    localparam int unsigned DC = 20; // short pass keeps the run brief
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic stby_n = 1'b0; // start in standby
    fdsup_prot_t prot = '0;
    fdsup_load_t load = '0; // clean load unless a scenario says
    logic wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic clr = 1'b0;
    logic signed [7:0] lvl = 8'sh00;
    logic pos, neg, oe_n, f_out, f_oe_n, bus_rel, f_pin;
    logic [7:0] ctrl;
    logic [1:0] gsel;
    logic [5:0] gdb;
    fdsup_stat_t st;
    int n_mismatch = 0;
    int compares = 0;

    fdsup_core #(.DIAG_CYCLES(DC)) dut_u (.i_clk(i_clk), .i_nrst(i_nrst),
        .i_standby_n(stby_n), .i_prot(prot), .i_load(load),
        .i_fault_pin(f_pin), .i_ctrl_wr(wr), .i_ctrl_data(wdata),
        .i_status_clr(clr), .i_level(lvl), .o_bridge_out_pos(pos),
        .o_bridge_out_neg(neg), .o_bridge_oe_n(oe_n), .o_fault_out(f_out),
        .o_fault_oe_n(f_oe_n), .o_bus_release(bus_rel), .o_ctrl(ctrl),
        .o_gain_sel(gsel), .o_gain_db(gdb), .o_status(st));
    fdsup_host_model host_u (.i_fault_out(f_out), .i_fault_oe_n(f_oe_n),
        .o_fault_pin(f_pin));

    // free running 50 MHz clock
    initial begin
        forever #10 i_clk = ~i_clk;
    end

    task automatic final_report();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [11:0] e,
        input logic [11:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    // bounded wait: 0 bridge hi-z, 1 fault pull, 2 busy, 3 verdict
    task automatic wait_for(input int sel, input logic [2:0] v,
        input int max);
        logic [2:0] s;
        for (int i = 0; i < max; i++) begin
            @(negedge i_clk);
            case (sel)
                0: s = {2'h0, oe_n};
                1: s = {2'h0, f_oe_n};
                2: s = {2'h0, st.diag_busy};
                default: s = st.verdict;
            endcase
            if (s === v) return;
        end
        chk("wait target", 12'(v), 12'(s));
        final_report();
    endtask

    task automatic wr_ctrl(input logic [7:0] d);
        @(posedge i_clk);
        wr <= 1'b1;
        wdata <= d;
        @(posedge i_clk);
        wr <= 1'b0;
    endtask

    // high cycles of each leg over one full 256 step ramp
    task automatic duty(input logic signed [7:0] l, input logic [8:0] ep,
        input logic [8:0] en);
        logic [8:0] np, nn;
        @(posedge i_clk);
        lvl <= l;
        cyc(8);
        np = 9'h000;
        nn = 9'h000;
        repeat (256) begin
            @(negedge i_clk);
            np += 9'(pos);
            nn += 9'(neg);
        end
        chk("pos duty", 12'(ep), 12'(np));
        chk("neg duty", 12'(en), 12'(nn));
    endtask

    task automatic t_boot();
        @(negedge i_clk);
        chk("bus release", 12'h001, 12'(bus_rel));
        chk("ctrl", 12'h000, 12'(ctrl));
        @(posedge i_clk);
        stby_n <= 1'b1;
        wait_for(2, 3'h1, 8);
        chk("bridge hiz", 12'h001, 12'(oe_n));
        wait_for(0, 3'h0, 2 * DC + 8);
        chk("verdict", 12'(FDSUP_V_NORMAL), 12'(st.verdict));
    endtask

    task automatic t_gain();
        logic [5:0] db [4] = '{6'h14, 6'h1a, 6'h20, 6'h24};
        for (int g = 0; g < 4; g++) begin
            wr_ctrl({2'(g), 6'h3f});
            cyc(2);
            @(negedge i_clk);
            chk("gain db", 12'(db[g]), 12'(gdb));
            chk("gain sel", 12'(g), 12'(gsel));
        end
    endtask

    task automatic t_pwm();
        duty(8'sh00, 9'h080, 9'h080);
        duty(8'sh14, 9'h094, 9'h06c);
        duty(-8'sh14, 9'h06c, 9'h094);
        wr_ctrl(8'h00);
        duty(8'sh64, 9'h081, 9'h07f);
        duty(-8'sh64, 9'h07f, 9'h081);
    endtask

    // first overvoltage skips the diagnostic, the second runs it
    task automatic t_ov();
        int b;
        b = 0;
        for (int k = 0; k < 2; k++) begin
            @(posedge i_clk);
            prot.supply_high_trip <= 1'b1;
            wait_for(1, 3'h0, 8);
            chk("ov status", 12'h001, 12'(st.supply_high_trip));
            @(posedge i_clk);
            prot.supply_high_trip <= 1'b0;
            for (int i = 0; i < 16; i++) begin
                @(negedge i_clk);
                b += int'(st.diag_busy);
            end
            chk("diag count", 12'(k), 12'(b > 0));
            wait_for(0, 3'h0, 2 * DC + 8);
        end
    endtask

    task automatic t_dc_open();
        @(posedge i_clk);
        load.open_load <= 1'b1;
        prot.dc_offset <= 1'b1;
        wait_for(1, 3'h0, 8);
        chk("dc status", 12'h001, 12'(st.dc_offset));
        chk("fault wire", 12'h000, 12'(f_pin));
        chk("bridge hiz", 12'h001, 12'(oe_n));
        @(posedge i_clk);
        prot.dc_offset <= 1'b0;
        wait_for(0, 3'h0, 4 * DC);
        chk("verdict", 12'(FDSUP_V_OPEN), 12'(st.verdict));
        chk("fault oe", 12'h001, 12'(f_oe_n));
        @(posedge i_clk);
        load.open_load <= 1'b0;
        clr <= 1'b1;
        @(posedge i_clk);
        clr <= 1'b0;
        @(negedge i_clk);
        chk("dc cleared", 12'h000, 12'(st.dc_offset));
    endtask

    task automatic t_short_ot();
        int n;
        n = 0;
        @(posedge i_clk);
        load.short_gnd <= 1'b1;
        prot.overcurrent_shutdown <= 1'b1;
        wait_for(1, 3'h0, 8);
        chk("bridge hiz", 12'h001, 12'(oe_n));
        chk("oc status", 12'h001, 12'(st.overcurrent_shutdown));
        @(posedge i_clk);
        prot.overcurrent_shutdown <= 1'b0;
        wait_for(2, 3'h1, 8);
        while (st.verdict !== FDSUP_V_GND && n < 8 * DC) begin
            @(negedge i_clk);
            n++;
        end
        // five passes of DC cycles each, a few edges of slack
        chk("five passes", 12'h001, 12'(n >= 5*DC-2 && n <= 5*DC+4));
        if (n >= 8 * DC) begin
            final_report();
        end
        // the wire follows the latched verdict one edge later
        @(negedge i_clk);
        chk("fault oe", 12'h000, 12'(f_oe_n));
        wait_for(2, 3'h1, 8);
        chk("bridge hiz", 12'h001, 12'(oe_n));
        @(posedge i_clk);
        prot.overtemp_shutdown <= 1'b1;
        wait_for(2, 3'h0, 6);
        chk("ot status", 12'h001, 12'(st.overtemp_shutdown));
        chk("fault line", 12'h000, 12'(st.fault_line));
        @(posedge i_clk);
        load.short_gnd <= 1'b0;
        prot.overtemp_shutdown <= 1'b0;
        wait_for(0, 3'h0, 4 * DC);
        chk("fault oe", 12'h001, 12'(f_oe_n));
    endtask

    task automatic t_uv();
        wr_ctrl(8'hc5);
        @(posedge i_clk);
        prot.supply_low_trip <= 1'b1;
        wait_for(1, 3'h0, 8);
        chk("ctrl", 12'h000, 12'(ctrl));
        chk("uv status", 12'h001, 12'(st.supply_low_trip));
        @(posedge i_clk);
        prot.supply_low_trip <= 1'b0;
        wait_for(0, 3'h0, 4 * DC);
    endtask

    // sel 0 enters standby, sel 1 a power-on reset
    task automatic t_off(input int sel);
        wr_ctrl(8'hc5);
        @(posedge i_clk);
        stby_n <= (sel != 0);
        prot.power_on_reset <= (sel == 1);
        wait_for(0, 3'h1, 8);
        chk("bus release", 12'h001, 12'(bus_rel));
        chk("ctrl", 12'h000, 12'(ctrl));
        @(posedge i_clk);
        stby_n <= 1'b1;
        prot.power_on_reset <= 1'b0;
        wait_for(0, 3'h0, 2 * DC + 12);
        chk("bus release", 12'h000, 12'(bus_rel));
    endtask

    initial begin
        cyc(16);
        i_nrst <= 1'b1;
        cyc(3);
        t_boot();
        t_gain();
        t_pwm();
        t_ov();
        t_dc_open();
        t_short_ot();
        t_uv();
        t_off(0);
        t_off(1);
        final_report();
    end
endmodule
